// ### logic/pg_tree_defines.vh
`ifndef PG_TREE_DEFINES_VH
`define PG_TREE_DEFINES_VH

// Register offsets on the internal register port of the serial interface.
`define OFS_RAIL_FAULT_MASK_SECOND 8'hA3
`define OFS_OUTPUT_ONE_RAIL_PG_SELECT 8'hA4
`define OFS_OUTPUT_ONE_MISC_PG_SELECT 8'hA5
`define OFS_OUTPUT_FOUR_RAIL_PG_SELECT 8'hA6
`define OFS_OUTPUT_FOUR_MISC_PG_SELECT 8'hA7

// Reset values.
`define RST_RAIL_FAULT_MASK_SECOND 8'h3F
`define RST_OUTPUT_ONE_RAIL_PG_SELECT 8'hC2
`define RST_OUTPUT_ONE_MISC_PG_SELECT 8'hAF
`define RST_OUTPUT_FOUR_RAIL_PG_SELECT 8'h00
`define RST_OUTPUT_FOUR_MISC_PG_SELECT 8'h00

// Layout of the second fault mask register.
`define FAULT_BLOCK_MSB 4
`define FAULT_BLOCK_WIDTH 5
`define FAULT_RSVD_MSB 7
`define FAULT_RSVD_LSB 5
`define FAULT_RSVD_WIDTH 3
`define FAULT_FIRST_AUX_LDO_BIT 4
`define FAULT_TERMINATION_LDO_BIT 3
`define FAULT_SECOND_B_SWITCH_BIT 2
`define FAULT_FIRST_B_SWITCH_BIT 1
`define FAULT_THIRD_AUX_LDO_BIT 0

// Layout of the first power-good select register of each output.
`define RAIL_SEL_SECOND_AUX_LDO_BIT 7
`define RAIL_SEL_LOAD_SWITCH_A_BIT 6
`define RAIL_SEL_STEP_DOWN_SIX_BIT 5
`define RAIL_SEL_STEP_DOWN_FIVE_BIT 4
`define RAIL_SEL_STEP_DOWN_FOUR_BIT 3
`define RAIL_SEL_STEP_DOWN_THREE_BIT 2
`define RAIL_SEL_STEP_DOWN_TWO_BIT 1
`define RAIL_SEL_STEP_DOWN_ONE_BIT 0

// Layout of the second power-good select register of each output.
`define MISC_SEL_CONTROL_FIVE_BIT 7
`define MISC_SEL_CONTROL_FOUR_BIT 6
`define MISC_SEL_CONTROL_TWO_BIT 5
`define MISC_SEL_CONTROL_ONE_BIT 4
`define MISC_SEL_TERMINATION_LDO_BIT 3
`define MISC_SEL_SECOND_B_SWITCH_BIT 2
`define MISC_SEL_FIRST_B_SWITCH_BIT 1
`define MISC_SEL_THIRD_AUX_LDO_BIT 0

// Widths, bit bounds and the idle read value.
`define REG_WIDTH 8
`define ADDR_WIDTH 8
`define TREE_WIDTH 16
`define PIN_COUNT 21
`define FAULT_BLOCK_LSB 0
`define MISC_PIN_MSB 15
`define FAULT_PIN_LSB 16
`define READ_IDLE 8'h00

`endif

// ### logic/pg_tree_member.v
`timescale 1ns/10ps
`default_nettype none

// A member counts as good when it reports good or when its mask bit excludes it.
module pg_tree_member #(
  parameter WIDTH = 16
) (
  input wire [WIDTH-1:0] member_good_i, // Good state of each member, high is good.
  input wire [WIDTH-1:0] member_mask_i, // Mask bit of each member, high excludes it.
  output wire tree_good_o // High while every included member is good.
);

  assign tree_good_o = &(member_good_i | member_mask_i);

endmodule

`default_nettype wire

// ### logic/power_good_tree_fault_mask.v
`include "pg_tree_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module power_good_tree_fault_mask (
  input wire sys_clk_i, // System clock, 200 MHz.
  input wire reset_n_i, // Synchronous reset, active low.
  input wire [`ADDR_WIDTH-1:0] reg_addr_i, // Register offset from the serial interface.
  input wire reg_wr_i, // Write strobe, one cycle per write.
  input wire reg_rd_i, // Read strobe, one cycle per read.
  input wire [`REG_WIDTH-1:0] reg_wdata_i, // Write data.
  output wire [`REG_WIDTH-1:0] reg_rdata_o, // Read data, held until the next read.
  output wire reg_hit_o, // High while the offset names a register of this block.
  input wire second_aux_ldo_pg_i, // Power good of the second auxiliary LDO.
  input wire load_switch_a_pg_i, // Power good of the A load switch.
  input wire step_down_rail_six_pg_i, // Power good of step-down rail six.
  input wire step_down_rail_five_pg_i, // Power good of step-down rail five.
  input wire step_down_rail_four_pg_i, // Power good of step-down rail four.
  input wire step_down_rail_three_pg_i, // Power good of step-down rail three.
  input wire step_down_rail_two_pg_i, // Power good of step-down rail two.
  input wire step_down_rail_one_pg_i, // Power good of step-down rail one.
  input wire control_input_five_i, // State of control input pin five.
  input wire control_input_four_i, // State of control input pin four.
  input wire control_input_two_i, // State of control input pin two.
  input wire control_input_one_i, // State of control input pin one.
  input wire termination_ldo_pg_i, // Power good of the termination LDO.
  input wire second_b_load_switch_pg_i, // Power good of the second B load switch.
  input wire first_b_load_switch_pg_i, // Power good of the first B load switch.
  input wire third_aux_ldo_pg_i, // Power good of the third auxiliary LDO.
  input wire first_aux_ldo_fault_i, // Power fault of the first auxiliary LDO.
  input wire termination_ldo_fault_i, // Power fault of the termination LDO.
  input wire second_b_load_switch_fault_i, // Power fault of the second B load switch.
  input wire first_b_load_switch_fault_i, // Power fault of the first B load switch.
  input wire third_aux_ldo_fault_i, // Power fault of the third auxiliary LDO.
  output wire general_output_one_power_good_o, // Power-good tree result of output one.
  output wire general_output_four_power_good_o, // Power-good tree result of output four.
  output wire fault_shutdown_o, // Shutdown request from an unmasked rail fault.
  output wire [`FAULT_BLOCK_WIDTH-1:0] fault_source_o // Unmasked faults, fault mask bit layout.
);

  reg [`PIN_COUNT-1:0] pin_meta;
  reg [`PIN_COUNT-1:0] pin_sync;
  wire [`PIN_COUNT-1:0] pin_raw;
  wire [`REG_WIDTH-1:0] rail_pg_sync;
  wire [`REG_WIDTH-1:0] misc_pg_sync;
  wire [`FAULT_BLOCK_WIDTH-1:0] fault_sync;

  reg [`FAULT_BLOCK_WIDTH-1:0] fault_block;
  reg [`REG_WIDTH-1:0] output_one_rail_pg_select;
  reg [`REG_WIDTH-1:0] output_one_misc_pg_select;
  reg [`REG_WIDTH-1:0] output_four_rail_pg_select;
  reg [`REG_WIDTH-1:0] output_four_misc_pg_select;
  wire [`REG_WIDTH-1:0] rail_fault_mask_second;

  reg [`REG_WIDTH-1:0] read_data;
  reg [`REG_WIDTH-1:0] next_read_data;
  reg next_hit;

  wire [`REG_WIDTH-1:0] rail_pg_raw;
  wire [`REG_WIDTH-1:0] misc_pg_raw;
  wire [`FAULT_BLOCK_WIDTH-1:0] fault_raw;

  wire tree_one_good;
  wire tree_four_good;
  reg output_one_good;
  reg output_four_good;
  reg shutdown_request;
  reg [`FAULT_BLOCK_WIDTH-1:0] fault_source;
  wire [`FAULT_BLOCK_WIDTH-1:0] next_fault_source;

  wire write_fault_mask;
  wire write_one_rail;
  wire write_one_misc;
  wire write_four_rail;
  wire write_four_misc;

  wire [`TREE_WIDTH-1:0] tree_members;
  wire [`TREE_WIDTH-1:0] tree_one_mask;
  wire [`TREE_WIDTH-1:0] tree_four_mask;

  // The reset value sits in a localparam so that its fields can be selected.
  localparam [`REG_WIDTH-1:0] FAULT_MASK_RESET = `RST_RAIL_FAULT_MASK_SECOND;
  localparam [`FAULT_RSVD_WIDTH-1:0] FAULT_RSVD_VALUE = FAULT_MASK_RESET[`FAULT_RSVD_MSB:`FAULT_RSVD_LSB];
  localparam [`FAULT_BLOCK_WIDTH-1:0] FAULT_BLOCK_RESET = FAULT_MASK_RESET[`FAULT_BLOCK_MSB:`FAULT_BLOCK_LSB];

  // Rail power-good inputs gathered in the layout of the first select register.
  assign rail_pg_raw[`RAIL_SEL_SECOND_AUX_LDO_BIT] = second_aux_ldo_pg_i;
  assign rail_pg_raw[`RAIL_SEL_LOAD_SWITCH_A_BIT] = load_switch_a_pg_i;
  assign rail_pg_raw[`RAIL_SEL_STEP_DOWN_SIX_BIT] = step_down_rail_six_pg_i;
  assign rail_pg_raw[`RAIL_SEL_STEP_DOWN_FIVE_BIT] = step_down_rail_five_pg_i;
  assign rail_pg_raw[`RAIL_SEL_STEP_DOWN_FOUR_BIT] = step_down_rail_four_pg_i;
  assign rail_pg_raw[`RAIL_SEL_STEP_DOWN_THREE_BIT] = step_down_rail_three_pg_i;
  assign rail_pg_raw[`RAIL_SEL_STEP_DOWN_TWO_BIT] = step_down_rail_two_pg_i;
  assign rail_pg_raw[`RAIL_SEL_STEP_DOWN_ONE_BIT] = step_down_rail_one_pg_i;

  // Control pins and remaining rails in the layout of the second select register.
  assign misc_pg_raw[`MISC_SEL_CONTROL_FIVE_BIT] = control_input_five_i;
  assign misc_pg_raw[`MISC_SEL_CONTROL_FOUR_BIT] = control_input_four_i;
  assign misc_pg_raw[`MISC_SEL_CONTROL_TWO_BIT] = control_input_two_i;
  assign misc_pg_raw[`MISC_SEL_CONTROL_ONE_BIT] = control_input_one_i;
  assign misc_pg_raw[`MISC_SEL_TERMINATION_LDO_BIT] = termination_ldo_pg_i;
  assign misc_pg_raw[`MISC_SEL_SECOND_B_SWITCH_BIT] = second_b_load_switch_pg_i;
  assign misc_pg_raw[`MISC_SEL_FIRST_B_SWITCH_BIT] = first_b_load_switch_pg_i;
  assign misc_pg_raw[`MISC_SEL_THIRD_AUX_LDO_BIT] = third_aux_ldo_pg_i;

  // Fault inputs in the layout of the second fault mask register.
  assign fault_raw[`FAULT_FIRST_AUX_LDO_BIT] = first_aux_ldo_fault_i;
  assign fault_raw[`FAULT_TERMINATION_LDO_BIT] = termination_ldo_fault_i;
  assign fault_raw[`FAULT_SECOND_B_SWITCH_BIT] = second_b_load_switch_fault_i;
  assign fault_raw[`FAULT_FIRST_B_SWITCH_BIT] = first_b_load_switch_fault_i;
  assign fault_raw[`FAULT_THIRD_AUX_LDO_BIT] = third_aux_ldo_fault_i;

  assign pin_raw = {fault_raw, misc_pg_raw, rail_pg_raw};

  // All pin inputs come from the analog side and are synchronised before use.
  // The first stage may go metastable, so only the second stage feeds any logic.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pin_meta <= {`PIN_COUNT{1'b0}};
      pin_sync <= {`PIN_COUNT{1'b0}};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign rail_pg_sync = pin_sync[`REG_WIDTH-1:0];
  assign misc_pg_sync = pin_sync[`MISC_PIN_MSB:`REG_WIDTH];
  assign fault_sync = pin_sync[`PIN_COUNT-1:`FAULT_PIN_LSB];

  // Reserved bits are constants and never take write data.
  assign rail_fault_mask_second = {FAULT_RSVD_VALUE, fault_block};

  // Write enables; offsets outside the map enable nothing and are ignored.
  assign write_fault_mask = reg_wr_i && (reg_addr_i == `OFS_RAIL_FAULT_MASK_SECOND);
  assign write_one_rail = reg_wr_i && (reg_addr_i == `OFS_OUTPUT_ONE_RAIL_PG_SELECT);
  assign write_one_misc = reg_wr_i && (reg_addr_i == `OFS_OUTPUT_ONE_MISC_PG_SELECT);
  assign write_four_rail = reg_wr_i && (reg_addr_i == `OFS_OUTPUT_FOUR_RAIL_PG_SELECT);
  assign write_four_misc = reg_wr_i && (reg_addr_i == `OFS_OUTPUT_FOUR_MISC_PG_SELECT);

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      fault_block <= FAULT_BLOCK_RESET;
    end else if (write_fault_mask) begin
      fault_block <= reg_wdata_i[`FAULT_BLOCK_MSB:`FAULT_BLOCK_LSB];
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      output_one_rail_pg_select <= `RST_OUTPUT_ONE_RAIL_PG_SELECT;
    end else if (write_one_rail) begin
      output_one_rail_pg_select <= reg_wdata_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      output_one_misc_pg_select <= `RST_OUTPUT_ONE_MISC_PG_SELECT;
    end else if (write_one_misc) begin
      output_one_misc_pg_select <= reg_wdata_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      output_four_rail_pg_select <= `RST_OUTPUT_FOUR_RAIL_PG_SELECT;
    end else if (write_four_rail) begin
      output_four_rail_pg_select <= reg_wdata_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      output_four_misc_pg_select <= `RST_OUTPUT_FOUR_MISC_PG_SELECT;
    end else if (write_four_misc) begin
      output_four_misc_pg_select <= reg_wdata_i;
    end
  end

  // Read decode; an unmapped offset reads as zero and drops the hit flag.
  always @* begin
    next_read_data = `READ_IDLE;
    next_hit = 1'b1;
    case (reg_addr_i)
      `OFS_RAIL_FAULT_MASK_SECOND: begin
        next_read_data = rail_fault_mask_second;
      end
      `OFS_OUTPUT_ONE_RAIL_PG_SELECT: begin
        next_read_data = output_one_rail_pg_select;
      end
      `OFS_OUTPUT_ONE_MISC_PG_SELECT: begin
        next_read_data = output_one_misc_pg_select;
      end
      `OFS_OUTPUT_FOUR_RAIL_PG_SELECT: begin
        next_read_data = output_four_rail_pg_select;
      end
      `OFS_OUTPUT_FOUR_MISC_PG_SELECT: begin
        next_read_data = output_four_misc_pg_select;
      end
      default: begin
        next_hit = 1'b0;
      end
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  // A read in the same cycle as a write to that register returns the old value.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      read_data <= `READ_IDLE;
    end else if (reg_rd_i) begin
      read_data <= next_read_data;
    end
  end

  assign reg_rdata_o = read_data;
  assign reg_hit_o = next_hit;

  assign tree_members = {misc_pg_sync, rail_pg_sync};
  assign tree_one_mask = {output_one_misc_pg_select, output_one_rail_pg_select};
  assign tree_four_mask = {output_four_misc_pg_select, output_four_rail_pg_select};

  // Power-good tree of general output one.
  pg_tree_member #(
    .WIDTH(`TREE_WIDTH)
  ) u_tree_one (
    .member_good_i(tree_members),
    .member_mask_i(tree_one_mask),
    .tree_good_o(tree_one_good)
  );

  // Power-good tree of general output four.
  pg_tree_member #(
    .WIDTH(`TREE_WIDTH)
  ) u_tree_four (
    .member_good_i(tree_members),
    .member_mask_i(tree_four_mask),
    .tree_good_o(tree_four_good)
  );

  // A fault counts only while its mask bit is clear.
  assign next_fault_source = fault_sync & ~fault_block;

  // Outputs are registered so the sequencing logic never sees a decode glitch.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      output_one_good <= 1'b0;
    end else begin
      output_one_good <= tree_one_good;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      output_four_good <= 1'b0;
    end else begin
      output_four_good <= tree_four_good;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      fault_source <= {`FAULT_BLOCK_WIDTH{1'b0}};
    end else begin
      fault_source <= next_fault_source;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      shutdown_request <= 1'b0;
    end else begin
      shutdown_request <= |next_fault_source;
    end
  end

  assign general_output_one_power_good_o = output_one_good;
  assign general_output_four_power_good_o = output_four_good;
  assign fault_shutdown_o = shutdown_request;
  assign fault_source_o = fault_source;

endmodule

`default_nettype wire

// ### verif/tree_mask_checker_sva.sv
`timescale 1ns/10ps
`default_nettype none
module tree_mask_checker (
  input wire logic sys_clk_i, // Clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic [7:0] reg_addr_i, // Offset.
  input wire logic reg_wr_i, // Write strobe.
  input wire logic reg_rd_i, // Read strobe.
  input wire logic [7:0] reg_wdata_i, // Write data.
  input wire logic [7:0] reg_rdata_o, // Read data.
  input wire logic reg_hit_o, // Offset hit.
  input wire logic fault_shutdown_o, // Shutdown.
  input wire logic [4:0] fault_source_o // Unmasked faults.
);
  logic [4:0] wdata_low;
  assign wdata_low = reg_wdata_i[4:0];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_hit_decode: assert property (reg_hit_o == (reg_addr_i >= 8'hA3 && reg_addr_i <= 8'hA7))
    else $error("hit flag wrong");
  chk_unmapped_read: assert property (reg_rd_i && !reg_hit_o |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  chk_reserved_read: assert property (reg_rd_i && reg_addr_i == 8'hA3 |=> reg_rdata_o[7:5] == 3'h1)
    else $error("reserved bits wrong");
  chk_shutdown_or: assert property (fault_shutdown_o == (|fault_source_o))
    else $error("shutdown disagrees with sources");
  chk_write_readback: assert property (reg_wr_i && reg_addr_i >= 8'hA4 && reg_addr_i <= 8'hA7 ##1
    reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("select readback wrong");
  chk_fault_readback: assert property (reg_wr_i && reg_addr_i == 8'hA3 ##1 reg_rd_i && !reg_wr_i &&
    reg_addr_i == 8'hA3 |=> reg_rdata_o == {3'h1, $past(wdata_low, 2)})
    else $error("fault mask readback wrong");
  chk_mask_blocks: assert property (reg_wr_i && reg_addr_i == 8'hA3 && wdata_low == 5'h1F |-> ##2
    fault_source_o == 5'h00)
    else $error("masked fault still reported");
endmodule
`default_nettype wire

// ### verif/platform_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module platform_seq_model (
  input wire logic sys_clk_i, // Clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic tree_one_i, // Tree result one.
  input wire logic tree_four_i, // Tree result four.
  input wire logic shutdown_i, // Shutdown request.
  output var logic rails_up_o // Platform runs.
);
  // A shutdown request drops the platform at once.
  always @(posedge sys_clk_i) begin
    if (!reset_n_i || shutdown_i) begin
      rails_up_o <= 1'b0;
    end else begin
      rails_up_o <= tree_one_i & tree_four_i;
    end
  end
endmodule
`default_nettype wire

// ### verif/power_good_tree_fault_mask_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CMP(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module power_good_tree_fault_mask_tb;
  typedef struct {string nm; logic [7:0] e;} note_t;
  note_t notes[$];
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_q = 1'b0, out_req = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rdata;
  logic [15:0] good = 16'hFFFF;
  logic [4:0] flt = 5'h00, src;
  logic hit, out1, out4, sd, up;
  logic [31:0] seed = 32'h0000_0001;
  logic [7:0] sh[5] = '{8'h3F, 8'hC2, 8'hAF, 8'h00, 8'h00};
  int n_fail = 0, compares = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  power_good_tree_fault_mask dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .reg_hit_o(hit),
    .second_aux_ldo_pg_i(good[7]), .load_switch_a_pg_i(good[6]), .step_down_rail_six_pg_i(good[5]),
    .step_down_rail_five_pg_i(good[4]), .step_down_rail_four_pg_i(good[3]), .step_down_rail_three_pg_i(good[2]),
    .step_down_rail_two_pg_i(good[1]), .step_down_rail_one_pg_i(good[0]), .control_input_five_i(good[15]),
    .control_input_four_i(good[14]), .control_input_two_i(good[13]), .control_input_one_i(good[12]),
    .termination_ldo_pg_i(good[11]), .second_b_load_switch_pg_i(good[10]), .first_b_load_switch_pg_i(good[9]),
    .third_aux_ldo_pg_i(good[8]), .first_aux_ldo_fault_i(flt[4]), .termination_ldo_fault_i(flt[3]),
    .second_b_load_switch_fault_i(flt[2]), .first_b_load_switch_fault_i(flt[1]), .third_aux_ldo_fault_i(flt[0]),
    .general_output_one_power_good_o(out1), .general_output_four_power_good_o(out4),
    .fault_shutdown_o(sd), .fault_source_o(src));
  platform_seq_model psm (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .tree_one_i(out1),
    .tree_four_i(out4), .shutdown_i(sd), .rails_up_o(up));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic take(input string nm, input logic [7:0] g);
    note_t n;
    if (notes.size() == 0) begin
      n_fail++;
      $display("mismatch %s exp note got %h", nm, g);
    end else begin
      n = notes.pop_front();
      `CMP(n.nm, n.e, g)
    end
  endtask
  always @(posedge sys_clk_i) begin
    if (rd_q) take("read", rdata);
    if (out_req) begin
      take("one", {7'h00, out1});
      take("four", {7'h00, out4});
      take("source", {3'h0, src});
      take("shutdown", {7'h00, sd});
      take("up", {7'h00, up});
    end
    rd_q <= reg_rd_i;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    notes.push_back('{$sformatf("reg %h", a), e});
    acc(1'b0, a, 8'h00);
  endtask
  task automatic chk(input logic e1, input logic e4, input logic [4:0] es);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    notes.push_back('{"one", {7'h00, e1}});
    notes.push_back('{"four", {7'h00, e4}});
    notes.push_back('{"source", {3'h0, es}});
    notes.push_back('{"shutdown", {7'h00, |es}});
    notes.push_back('{"up", {7'h00, !(|es) && e1 && e4}});
    out_req <= 1'b1;
    @(posedge sys_clk_i);
    out_req <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    $display("mismatch timeout exp done got hang");
    print_verdict();
  end
  initial begin
    logic [31:0] r;
    logic [15:0] p;
    logic [2:0] x;
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'hA3 + i, sh[i]);
    rd(8'hA8, 8'h00);
    chk(1'b1, 1'b1, 5'h00);
    good <= 16'h7FFD;
    chk(1'b1, 1'b0, 5'h00);
    good <= 16'hBFFF;
    chk(1'b0, 1'b0, 5'h00);
    good <= 16'hFFFF;
    acc(1'b1, 8'hA2, 8'hFF);
    acc(1'b1, 8'hA3, 8'hE0);
    rd(8'hA3, 8'h20);
    flt <= 5'h1F;
    chk(1'b1, 1'b1, 5'h1F);
    acc(1'b1, 8'hA3, 8'h1F);
    rd(8'hA3, 8'h3F);
    chk(1'b1, 1'b1, 5'h00);
    for (int k = 0; k < 40; k++) begin
      for (int j = 0; j < 5; j++) begin
        r = rnd();
        sh[j] = (j == 0) ? {3'h1, r[4:0]} : r[7:0];
        acc(1'b1, 8'hA3 + j, r[7:0]);
      end
      r = rnd();
      x = r[11:9] % 5;
      rd(8'hA3 + x, sh[x]);
      p = r[31] ? 16'hFFFF : ~(16'h0001 << r[3:0]);
      good <= p;
      flt <= r[8:4];
      chk(&(p | {sh[2], sh[1]}), &(p | {sh[4], sh[3]}), r[8:4] & ~sh[0][4:0]);
    end
    repeat (2) @(posedge sys_clk_i);
    if (notes.size() != 0) begin
      n_fail++;
      $display("mismatch notes exp 0 got %0d", notes.size());
    end
    print_verdict();
  end
endmodule
bind power_good_tree_fault_mask tree_mask_checker chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .fault_shutdown_o(fault_shutdown_o),
  .fault_source_o(fault_source_o));
`default_nettype wire
